/* sspc_defs.svh */
// Register map, field layout and code constants of the sector program controller
// What this block does
// - An erase of the EEPROM-like memory covers exactly one 256-byte sector.
// - For EEPROM-like memory the sector comes from page-select bits 1-0 and bits 5-2 are ignored.
// - The offset register gives the low byte of the byte address inside the sector.
// - For main flash the sector comes from page-select bits 5-2 and bits 1-0 are the high offset bits.
// - A program operation writes the data register byte into the addressed location.
// - Type code 0xE6 asks for sector erase and 0x6E for byte programming, nothing else.
// - The first key must hold 5 or the operation is terminated.
// - The second key must hold hexadecimal A or the operation is terminated.
// - The third key must hold 9 or the operation is terminated.
// - The fourth key must hold 6 or the operation is terminated.
// - The processor is held idle while an operation runs and released when it ends.
`ifndef SSPC_DEFS_SVH
`define SSPC_DEFS_SVH

// Register indices; byte address is four times the index
`define SSPC_IDX_TYPE 8'hf2
`define SSPC_IDX_KEY1 8'hf3
`define SSPC_IDX_KEY2 8'hf4
`define SSPC_IDX_KEY3 8'hf5
`define SSPC_IDX_KEY4 8'hf6
`define SSPC_IDX_PAGE 8'hf7
`define SSPC_IDX_OFFSET 8'hfb
`define SSPC_IDX_DATA 8'hfc
`define SSPC_IDX_STATUS 8'hfd

`define SSPC_RESET_BYTE 8'h00
`define SSPC_PAGE_W 6

`define SSPC_TYPE_ERASE 8'he6
`define SSPC_TYPE_PROG 8'h6e
`define SSPC_KEY1_VAL 4'h5
`define SSPC_KEY2_VAL 4'ha
`define SSPC_KEY3_VAL 4'h9
`define SSPC_KEY4_VAL 4'h6

`define SSPC_MAIN_SECT_BYTES 11'h400
`define SSPC_EEP_SECT_BYTES 11'h100

// Status register bits
`define SSPC_ST_BUSY 0
`define SSPC_ST_ABORT 1
`define SSPC_ST_DONE 2

`endif

/* sspc_pkg.sv */
// Types shared by the sector program controller modules
package sspc_pkg;
    typedef enum logic [5:0] {
        SSPC_IDLE = 6'b000001,
        SSPC_ARMED = 6'b000010,
        SSPC_K1 = 6'b000100,
        SSPC_K2 = 6'b001000,
        SSPC_K3 = 6'b010000,
        SSPC_BUSY = 6'b100000
    } sspc_state_t;
endpackage : sspc_pkg

/* sspc_unlock.sv */
// Unlock sequencer: type code, four ordered keys, launch and wait
`timescale 1ns/1ps
`include "sspc_defs.svh"
module sspc_unlock
    import sspc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic wr_type_i,
    input wire logic [3:0] wr_key_i,
    input wire logic [7:0] wdata_i,
    input wire logic done_i,
    output logic launch_o,
    output logic abort_o,
    output logic clear_o,
    output logic busy_o
);
    sspc_state_t state_r, state_nxt;

    always_comb begin
        state_nxt = state_r;
        launch_o = 1'b0;
        abort_o = 1'b0;
        unique case (state_r)
            SSPC_IDLE, SSPC_ARMED: begin
                if (wr_type_i) begin
                    // Any other code leaves the sequence unarmed
                    if (wdata_i == `SSPC_TYPE_ERASE || wdata_i == `SSPC_TYPE_PROG) begin
                        state_nxt = SSPC_ARMED;
                    end else begin
                        state_nxt = SSPC_IDLE;
                    end
                end else if (state_r == SSPC_ARMED && wr_key_i != 4'h0) begin
                    if (wr_key_i == 4'b0001 && wdata_i[3:0] == `SSPC_KEY1_VAL) begin
                        state_nxt = SSPC_K1;
                    end else begin
                        state_nxt = SSPC_IDLE;
                        abort_o = 1'b1;
                    end
                end else if (state_r == SSPC_IDLE && wr_key_i != 4'h0) begin
                    abort_o = 1'b1;
                end
            end
            SSPC_K1: begin
                if (wr_type_i || wr_key_i != 4'h0) begin
                    if (wr_key_i == 4'b0010 && wdata_i[3:0] == `SSPC_KEY2_VAL) begin
                        state_nxt = SSPC_K2;
                    end else begin
                        state_nxt = SSPC_IDLE;
                        abort_o = 1'b1;
                    end
                end
            end
            SSPC_K2: begin
                if (wr_type_i || wr_key_i != 4'h0) begin
                    if (wr_key_i == 4'b0100 && wdata_i[3:0] == `SSPC_KEY3_VAL) begin
                        state_nxt = SSPC_K3;
                    end else begin
                        state_nxt = SSPC_IDLE;
                        abort_o = 1'b1;
                    end
                end
            end
            SSPC_K3: begin
                if (wr_type_i || wr_key_i != 4'h0) begin
                    if (wr_key_i == 4'b1000 && wdata_i[3:0] == `SSPC_KEY4_VAL) begin
                        state_nxt = SSPC_BUSY;
                        launch_o = 1'b1;
                    end else begin
                        state_nxt = SSPC_IDLE;
                        abort_o = 1'b1;
                    end
                end
            end
            SSPC_BUSY: begin
                // Bus writes are not expected here: the processor is idle
                if (done_i) begin
                    state_nxt = SSPC_IDLE;
                end
            end
            default: state_nxt = SSPC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_r <= SSPC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign busy_o = (state_r == SSPC_BUSY);
    assign clear_o = abort_o | (busy_o & done_i);

    a_launch_needs_key4: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        launch_o |-> state_r == SSPC_K3 && wr_key_i[3] && wdata_i[3:0] == `SSPC_KEY4_VAL)
        else $error("launch without full key sequence");
    a_bad_key1_abort: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (state_r == SSPC_ARMED && wr_key_i == 4'b0001 && wdata_i[3:0] != 4'h5)
        |=> state_r == SSPC_IDLE)
        else $error("wrong first key did not terminate");
    a_busy_till_done: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (busy_o && !done_i) |=> busy_o)
        else $error("busy dropped before done");
    c_launch: cover property (@(posedge ref_clk_i) disable iff (reset_i) launch_o);
    c_abort: cover property (@(posedge ref_clk_i) disable iff (reset_i) abort_o);
endmodule : sspc_unlock

/* sspc_ctrl.sv */
// APB register front end and launch path for self sector programming
`timescale 1ns/1ps
`include "sspc_defs.svh"
module sspc_ctrl
    import sspc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic target_eeprom_i,
    input wire logic flash_done_i,
    output logic flash_start_o,
    output logic flash_erase_o,
    output logic flash_program_o,
    output logic flash_eeprom_o,
    output logic [13:0] flash_addr_o,
    output logic [10:0] flash_len_o,
    output logic [7:0] flash_data_o,
    output logic cpu_idle_o
);
    function automatic logic [11:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'b00, idx, 2'b00};
    endfunction : reg_addr

    function automatic logic [13:0] byte_addr(input logic eep, input logic [5:0] page,
                                              input logic [7:0] offs);
        if (eep) begin
            byte_addr = {4'h0, page[1:0], offs};
        end else begin
            byte_addr = {page[5:2], page[1:0], offs};
        end
    endfunction : byte_addr

    logic [7:0] type_r, type_nxt;
    logic [3:0] key_r [4];
    logic [3:0] key_nxt [4];
    logic [5:0] page_r, page_nxt;
    logic [7:0] offs_r, offs_nxt;
    logic [7:0] data_r, data_nxt;
    logic abort_seen_r, abort_seen_nxt;
    logic done_seen_r, done_seen_nxt;
    logic start_r, start_nxt;
    logic erase_r, erase_nxt;
    logic prog_r, prog_nxt;
    logic eep_r, eep_nxt;
    logic [13:0] addr_r, addr_nxt;
    logic [10:0] len_r, len_nxt;
    logic [7:0] fdata_r, fdata_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic access;
    logic mapped;
    logic wr_en;
    logic rd_en;
    logic wr_type;
    logic [3:0] wr_key;
    logic launch;
    logic abort;
    logic clear;
    logic busy;

    assign access = psel & penable;
    assign wr_en = access & pwrite & mapped;
    // Read data is fetched in the setup cycle so it stands through the access phase
    assign rd_en = psel & ~penable & ~pwrite & mapped;
    assign wr_type = wr_en && paddr == reg_addr(`SSPC_IDX_TYPE);

    always_comb begin
        mapped = 1'b0;
        wr_key = 4'h0;
        unique case (paddr)
            reg_addr(`SSPC_IDX_TYPE), reg_addr(`SSPC_IDX_PAGE), reg_addr(`SSPC_IDX_OFFSET),
            reg_addr(`SSPC_IDX_DATA), reg_addr(`SSPC_IDX_STATUS): mapped = 1'b1;
            reg_addr(`SSPC_IDX_KEY1): begin
                mapped = 1'b1;
                wr_key[0] = wr_en;
            end
            reg_addr(`SSPC_IDX_KEY2): begin
                mapped = 1'b1;
                wr_key[1] = wr_en;
            end
            reg_addr(`SSPC_IDX_KEY3): begin
                mapped = 1'b1;
                wr_key[2] = wr_en;
            end
            reg_addr(`SSPC_IDX_KEY4): begin
                mapped = 1'b1;
                wr_key[3] = wr_en;
            end
            default: mapped = 1'b0;
        endcase
    end

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = rdata_r;

    sspc_unlock u_unlock (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .wr_type_i(wr_type),
        .wr_key_i(wr_key),
        .wdata_i(pwdata[7:0]),
        .done_i(flash_done_i),
        .launch_o(launch),
        .abort_o(abort),
        .clear_o(clear),
        .busy_o(busy)
    );

    // Register file next state
    always_comb begin
        type_nxt = type_r;
        key_nxt = key_r;
        page_nxt = page_r;
        offs_nxt = offs_r;
        data_nxt = data_r;
        if (wr_type) begin
            type_nxt = pwdata[7:0];
        end
        for (int i = 0; i < 4; i++) begin
            if (wr_key[i]) begin
                key_nxt[i] = pwdata[3:0];
            end
        end
        if (wr_en && paddr == reg_addr(`SSPC_IDX_PAGE)) begin
            page_nxt = pwdata[5:0];
        end
        if (wr_en && paddr == reg_addr(`SSPC_IDX_OFFSET)) begin
            offs_nxt = pwdata[7:0];
        end
        if (wr_en && paddr == reg_addr(`SSPC_IDX_DATA)) begin
            data_nxt = pwdata[7:0];
        end
        // Clear wins over the write that caused an abort
        if (clear) begin
            type_nxt = `SSPC_RESET_BYTE;
            for (int i = 0; i < 4; i++) begin
                key_nxt[i] = 4'h0;
            end
        end
    end

    // Status and read data
    always_comb begin
        abort_seen_nxt = abort_seen_r;
        done_seen_nxt = done_seen_r;
        if (launch) begin
            abort_seen_nxt = 1'b0;
            done_seen_nxt = 1'b0;
        end
        if (abort) begin
            abort_seen_nxt = 1'b1;
        end
        if (busy && flash_done_i) begin
            done_seen_nxt = 1'b1;
        end
        rdata_nxt = 32'h0;
        if (rd_en) begin
            unique case (paddr)
                reg_addr(`SSPC_IDX_TYPE): rdata_nxt = {24'h0, type_r};
                reg_addr(`SSPC_IDX_KEY1): rdata_nxt = {28'h0, key_r[0]};
                reg_addr(`SSPC_IDX_KEY2): rdata_nxt = {28'h0, key_r[1]};
                reg_addr(`SSPC_IDX_KEY3): rdata_nxt = {28'h0, key_r[2]};
                reg_addr(`SSPC_IDX_KEY4): rdata_nxt = {28'h0, key_r[3]};
                reg_addr(`SSPC_IDX_PAGE): rdata_nxt = {26'h0, page_r};
                reg_addr(`SSPC_IDX_OFFSET): rdata_nxt = {24'h0, offs_r};
                reg_addr(`SSPC_IDX_DATA): rdata_nxt = {24'h0, data_r};
                default: rdata_nxt = {29'h0, done_seen_r, abort_seen_r, busy};
            endcase
        end
    end

    // Flash request latched at launch so later writes cannot disturb it
    always_comb begin
        start_nxt = launch;
        erase_nxt = erase_r;
        prog_nxt = prog_r;
        eep_nxt = eep_r;
        addr_nxt = addr_r;
        len_nxt = len_r;
        fdata_nxt = fdata_r;
        if (launch) begin
            erase_nxt = (type_r == `SSPC_TYPE_ERASE);
            prog_nxt = (type_r == `SSPC_TYPE_PROG);
            eep_nxt = target_eeprom_i;
            addr_nxt = byte_addr(target_eeprom_i, page_r, offs_r);
            fdata_nxt = data_r;
            if (type_r == `SSPC_TYPE_ERASE) begin
                // Erase starts at the sector base
                addr_nxt[7:0] = 8'h00;
                if (!target_eeprom_i) begin
                    addr_nxt[9:8] = 2'b00;
                end
            end
            len_nxt = target_eeprom_i ? `SSPC_EEP_SECT_BYTES : `SSPC_MAIN_SECT_BYTES;
        end else if (busy && flash_done_i) begin
            erase_nxt = 1'b0;
            prog_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            type_r <= `SSPC_RESET_BYTE;
            for (int i = 0; i < 4; i++) begin
                key_r[i] <= 4'h0;
            end
            page_r <= 6'h00;
            offs_r <= `SSPC_RESET_BYTE;
            data_r <= `SSPC_RESET_BYTE;
            abort_seen_r <= 1'b0;
            done_seen_r <= 1'b0;
            start_r <= 1'b0;
            erase_r <= 1'b0;
            prog_r <= 1'b0;
            eep_r <= 1'b0;
            addr_r <= 14'h0000;
            len_r <= 11'h000;
            fdata_r <= 8'h00;
            rdata_r <= 32'h0;
        end else begin
            type_r <= type_nxt;
            key_r <= key_nxt;
            page_r <= page_nxt;
            offs_r <= offs_nxt;
            data_r <= data_nxt;
            abort_seen_r <= abort_seen_nxt;
            done_seen_r <= done_seen_nxt;
            start_r <= start_nxt;
            erase_r <= erase_nxt;
            prog_r <= prog_nxt;
            eep_r <= eep_nxt;
            addr_r <= addr_nxt;
            len_r <= len_nxt;
            fdata_r <= fdata_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign flash_start_o = start_r;
    assign flash_erase_o = erase_r;
    assign flash_program_o = prog_r;
    assign flash_eeprom_o = eep_r;
    assign flash_addr_o = addr_r;
    assign flash_len_o = len_r;
    assign flash_data_o = fdata_r;
    // Holds the processor from the launching write until done
    assign cpu_idle_o = busy;

    a_start_after_launch: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        launch |=> flash_start_o && cpu_idle_o)
        else $error("start or idle missing after launch");
    a_clear_type_keys: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        clear |=> type_r == 8'h00 && key_r[3] == 4'h0)
        else $error("type or key not cleared");
    a_eep_len_256: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (launch && target_eeprom_i) |=> flash_len_o == 11'h100 && flash_addr_o[13:10] == 4'h0)
        else $error("eeprom sector size wrong");
    a_eep_sector_bits: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (launch && target_eeprom_i) |=> flash_addr_o[9:8] == $past(page_r[1:0]))
        else $error("eeprom sector not taken from low page bits");
    a_main_addr_map: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (launch && !target_eeprom_i && type_r == 8'h6e)
        |=> flash_addr_o == {$past(page_r), $past(offs_r)})
        else $error("main flash address wrong");
    a_main_sector_bits: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (launch && !target_eeprom_i) |=> flash_addr_o[13:10] == $past(page_r[5:2]))
        else $error("main flash sector not taken from high page bits");
    a_erase_at_base: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (launch && type_r == `SSPC_TYPE_ERASE) |=> flash_addr_o[7:0] == 8'h00)
        else $error("erase does not start at sector base");
    a_prog_data_copy: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        launch |=> flash_data_o == $past(data_r))
        else $error("program data not copied");
    a_launch_type_valid: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        launch |-> type_r == `SSPC_TYPE_ERASE || type_r == `SSPC_TYPE_PROG)
        else $error("launch with an unknown type code");
    a_one_op_kind: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        flash_start_o |-> flash_erase_o != flash_program_o)
        else $error("start without exactly one operation");
    a_release_on_done: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (busy && flash_done_i) |=> !cpu_idle_o && !flash_erase_o && !flash_program_o)
        else $error("operation not released after done");
    c_erase_run: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        flash_start_o && flash_erase_o);
    c_prog_done: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        flash_program_o ##[1:50] flash_done_i);
endmodule : sspc_ctrl

/* self_sector_program_ctrl_bench.sv */
// Self-checking bench for the self sector programming controller
`timescale 1ns/1ps
`include "sspc_defs.svh"
module self_sector_program_ctrl_bench;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic target_eeprom_i = 1'b0;
    logic flash_done_i = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic flash_start_o;
    logic flash_erase_o;
    logic flash_program_o;
    logic flash_eeprom_o;
    logic [13:0] flash_addr_o;
    logic [10:0] flash_len_o;
    logic [7:0] flash_data_o;
    logic cpu_idle_o;
    int fails = 0;
    int cmp_count = 0;
    int starts = 0;
    int exp_starts = 0;
    int cycles = 0;
    logic [7:0] key_idx [4] = '{`SSPC_IDX_KEY1, `SSPC_IDX_KEY2, `SSPC_IDX_KEY3, `SSPC_IDX_KEY4};
    logic [3:0] key_val [4] = '{`SSPC_KEY1_VAL, `SSPC_KEY2_VAL, `SSPC_KEY3_VAL, `SSPC_KEY4_VAL};
    logic [7:0] reg_idx [8] = '{`SSPC_IDX_TYPE, `SSPC_IDX_KEY1, `SSPC_IDX_KEY2, `SSPC_IDX_KEY3,
        `SSPC_IDX_KEY4, `SSPC_IDX_PAGE, `SSPC_IDX_OFFSET, `SSPC_IDX_DATA};

    sspc_ctrl i_dut (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .target_eeprom_i(target_eeprom_i),
        .flash_done_i(flash_done_i),
        .flash_start_o(flash_start_o),
        .flash_erase_o(flash_erase_o),
        .flash_program_o(flash_program_o),
        .flash_eeprom_o(flash_eeprom_o),
        .flash_addr_o(flash_addr_o),
        .flash_len_o(flash_len_o),
        .flash_data_o(flash_data_o),
        .cpu_idle_o(cpu_idle_o)
    );

    always #12.5 ref_clk_i = ~ref_clk_i;

    // Launch pulses counted here so a stray second pulse is caught
    always @(posedge ref_clk_i) begin
        cycles++;
        if (flash_start_o === 1'b1) begin
            starts++;
        end
        if (cycles > 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : check

    // Returns in the time step of the access edge; outputs are looked at later
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp,
                          input logic [31:0] mask);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        check(what, exp, r & mask);
    endtask : rd_chk

    task automatic pulse_done();
        @(posedge ref_clk_i);
        flash_done_i <= 1'b1;
        @(posedge ref_clk_i);
        flash_done_i <= 1'b0;
        @(negedge ref_clk_i);
    endtask : pulse_done

    task automatic test_reset_map();
        logic [31:0] r;
        logic e;
        foreach (reg_idx[i]) rd_chk("reset value", reg_idx[i], 32'h0, 32'hffff_ffff);
        rd_chk("status reset", `SSPC_IDX_STATUS, 32'h0, 32'hffff_ffff);
        wr(`SSPC_IDX_PAGE, 32'hffff_ffff);
        rd_chk("page width", `SSPC_IDX_PAGE, 32'h3f, 32'hffff_ffff);
        wr(`SSPC_IDX_OFFSET, 32'h0000_01ab);
        rd_chk("offset width", `SSPC_IDX_OFFSET, 32'hab, 32'hffff_ffff);
        wr(`SSPC_IDX_DATA, 32'hffff_ff5a);
        rd_chk("data width", `SSPC_IDX_DATA, 32'h5a, 32'hffff_ffff);
        apb(1'b0, 8'h10, 32'h0, r, e);
        check("unmapped read err", 32'h1, {31'h0, e});
        check("unmapped read data", 32'h0, r);
        apb(1'b1, 8'h10, 32'hff, r, e);
        check("unmapped write err", 32'h1, {31'h0, e});
        pulse_done();
        check("idle done ignored", 32'h0, {31'h0, cpu_idle_o});
        rd_chk("status after stray done", `SSPC_IDX_STATUS, 32'h0, 32'hffff_ffff);
    endtask : test_reset_map

    // Sequence is broken by the last write; nothing may launch and all keys clear
    task automatic abort_seq(input logic [7:0] ty, input int n_good, input logic [7:0] bad_idx,
                             input logic [31:0] bad_val);
        wr(`SSPC_IDX_TYPE, {24'h0, ty});
        rd_chk("type readback", `SSPC_IDX_TYPE, {24'h0, ty}, 32'hffff_ffff);
        for (int i = 0; i < n_good; i++) wr(key_idx[i], {28'h0, key_val[i]});
        wr(bad_idx, bad_val);
        rd_chk("abort flag", `SSPC_IDX_STATUS, 32'h2, 32'h3);
        rd_chk("type cleared", `SSPC_IDX_TYPE, 32'h0, 32'hffff_ffff);
        foreach (key_idx[i]) rd_chk("key cleared", key_idx[i], 32'h0, 32'hffff_ffff);
        check("no idle on abort", 32'h0, {31'h0, cpu_idle_o});
        check("launch count", exp_starts, starts);
    endtask : abort_seq

    task automatic test_aborts();
        abort_seq(`SSPC_TYPE_PROG, 0, key_idx[0], {28'h0, key_val[0] ^ 4'h1});
        abort_seq(`SSPC_TYPE_PROG, 1, key_idx[1], {28'h0, key_val[1] ^ 4'h8});
        abort_seq(`SSPC_TYPE_ERASE, 2, key_idx[2], {28'h0, key_val[2] ^ 4'h2});
        abort_seq(`SSPC_TYPE_ERASE, 3, key_idx[3], {28'h0, key_val[3] ^ 4'h4});
        abort_seq(`SSPC_TYPE_ERASE, 1, `SSPC_IDX_KEY3, {28'h0, key_val[2]});
        abort_seq(`SSPC_TYPE_PROG, 2, `SSPC_IDX_TYPE, {24'h0, `SSPC_TYPE_PROG});
        abort_seq(8'h55, 0, `SSPC_IDX_KEY1, {28'h0, key_val[0]});
    endtask : test_aborts

    task automatic run_op(input logic [7:0] ty, input logic eep, input logic [5:0] page,
                          input logic [7:0] off, input logic [7:0] dat);
        logic er;
        logic [13:0] ea;
        er = (ty == `SSPC_TYPE_ERASE);
        ea = eep ? {4'h0, page[1:0], off} : {page, off};
        if (er) begin
            ea[7:0] = 8'h00;
            if (!eep) begin
                ea[9:8] = 2'b00;
            end
        end
        target_eeprom_i <= eep;
        wr(`SSPC_IDX_PAGE, {26'h0, page});
        wr(`SSPC_IDX_OFFSET, {24'h0, off});
        wr(`SSPC_IDX_DATA, {24'h0, dat});
        wr(`SSPC_IDX_TYPE, {24'h0, ty});
        for (int i = 0; i < 4; i++) begin
            wr(key_idx[i], {28'h0, key_val[i]});
            if (i < 3) rd_chk("key held", key_idx[i], {28'h0, key_val[i]}, 32'hffff_ffff);
        end
        exp_starts++;
        // Start stands for one cycle after the last key edge
        @(negedge ref_clk_i);
        check("start pulse", 32'h1, {31'h0, flash_start_o});
        check("cpu idle", 32'h1, {31'h0, cpu_idle_o});
        check("erase sel", {31'h0, er}, {31'h0, flash_erase_o});
        check("program sel", {31'h0, !er}, {31'h0, flash_program_o});
        check("target", {31'h0, eep}, {31'h0, flash_eeprom_o});
        check("address", {18'h0, ea}, {18'h0, flash_addr_o});
        if (er) check("length", eep ? 32'h100 : 32'h400, {21'h0, flash_len_o});
        if (!er) check("data", {24'h0, dat}, {24'h0, flash_data_o});
        rd_chk("busy status", `SSPC_IDX_STATUS, 32'h1, 32'hffff_ffff);
        check("still idle", 32'h1, {31'h0, cpu_idle_o});
        pulse_done();
        check("idle released", 32'h0, {31'h0, cpu_idle_o});
        check("op released", 32'h0, {31'h0, flash_erase_o | flash_program_o});
        rd_chk("done status", `SSPC_IDX_STATUS, 32'h4, 32'hffff_ffff);
        rd_chk("type cleared", `SSPC_IDX_TYPE, 32'h0, 32'hffff_ffff);
        foreach (key_idx[i]) rd_chk("key cleared", key_idx[i], 32'h0, 32'hffff_ffff);
        check("launch count", exp_starts, starts);
    endtask : run_op

    task automatic test_ops();
        run_op(`SSPC_TYPE_ERASE, 1'b1, 6'b111101, 8'h77, 8'h00);
        // Each programmed byte is a location never programmed before
        run_op(`SSPC_TYPE_PROG, 1'b1, 6'b101110, 8'h3c, 8'ha5);
        run_op(`SSPC_TYPE_ERASE, 1'b0, 6'b110110, 8'h81, 8'h00);
        run_op(`SSPC_TYPE_PROG, 1'b0, 6'b011011, 8'hc3, 8'h5a);
    endtask : test_ops

    initial begin
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        test_reset_map();
        test_aborts();
        test_ops();
        abort_seq(`SSPC_TYPE_PROG, 3, key_idx[3], 32'h0000_0000);
        tally_and_finish();
    end
endmodule : self_sector_program_ctrl_bench
